// ===== srcs_pkg.sv
// Shared constants and types of the receive and activity-scan sequencer.
// Assumes one clock domain; all users name items as srcs_pkg::name.
package srcs_pkg;

  // Width of a buffer address and of a buffer byte.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  // Number of bytes in the shared data buffer.
  localparam int unsigned BUF_DEPTH = 256;

  // Mode request codes presented on the mode request port.
  localparam logic [2:0] REQ_SLEEP = 3'h0;
  localparam logic [2:0] REQ_STANDBY = 3'h1;
  localparam logic [2:0] REQ_TX = 3'h3;
  localparam logic [2:0] REQ_RX_CONT = 3'h5;
  localparam logic [2:0] REQ_RX_SINGLE = 3'h6;
  localparam logic [2:0] REQ_SCAN = 3'h7;

  // Bit positions of the event flags.
  localparam int unsigned F_RX_DONE = 0;
  localparam int unsigned F_TIMEOUT = 1;
  localparam int unsigned F_HEADER = 2;
  localparam int unsigned F_CRC_ERR = 3;
  localparam int unsigned F_SCAN_DONE = 4;
  localparam int unsigned F_ACTIVITY = 5;
  localparam int unsigned F_TX_DONE = 6;
  localparam int unsigned F_HOP = 7;
  localparam int unsigned NUM_FLAGS = 8;

  // Pin route codes for each general pin.
  localparam logic [1:0] ROUTE_A = 2'h0;
  localparam logic [1:0] ROUTE_B = 2'h1;
  localparam logic [1:0] ROUTE_C = 2'h2;
  localparam logic [1:0] ROUTE_NONE = 2'h3;

  // Reset values.
  localparam logic [NUM_FLAGS-1:0] FLAGS_RST = 8'h00;
  localparam logic [ADDR_W-1:0] PTR_RST = 8'h00;

  // Clock output divider: half period in system clocks.
  localparam int unsigned CLOCK_OUTPUT_HALF = 4;
  localparam logic [3:0] CLOCK_OUTPUT_HALF_M1 = 4'(CLOCK_OUTPUT_HALF - 1);

  // Operating modes of the sequencer.
  typedef enum logic [2:0] {
    M_SLEEP, M_STANDBY, M_TX, M_RX_CONT, M_RX_SINGLE, M_SCAN
  } srcs_mode_t;

  // Progress of a reception inside a receive mode.
  typedef enum logic [1:0] {
    RX_PREAMBLE, RX_HEADER, RX_PAYLOAD
  } srcs_rx_t;

endpackage : srcs_pkg

// ===== srcs_buffer.sv
// Byte buffer shared by the demodulator and the host access port.
// Assumes a single clock; clear wipes every byte in one cycle.
module srcs_buffer #(
  parameter int unsigned DEPTH = srcs_pkg::BUF_DEPTH
) (
  // Clock, reset and enable.
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Whole-buffer wipe.
  input wire logic i_clear,
  // Demodulator write port, above the host port, below the wipe.
  input wire logic i_dem_we,
  input wire logic [srcs_pkg::ADDR_W-1:0] i_dem_addr,
  input wire logic [srcs_pkg::DATA_W-1:0] i_dem_data,
  // Host access port.
  input wire logic i_host_we,
  input wire logic i_host_re,
  input wire logic [srcs_pkg::ADDR_W-1:0] i_host_addr,
  input wire logic [srcs_pkg::DATA_W-1:0] i_host_data,
  output logic [srcs_pkg::DATA_W-1:0] o_rdata
);

  // All state: storage and the registered read byte.
  typedef struct packed {
    logic [DEPTH-1:0][srcs_pkg::DATA_W-1:0] mem;
    logic [srcs_pkg::DATA_W-1:0] rdata;
  } srcs_buf_t;

  srcs_buf_t s_q;
  srcs_buf_t s_d;

  // Next state: wipe, then demodulator write, then host write or read.
  always_comb begin
    s_d = s_q;
    if (i_clear) begin
      s_d.mem = '0;
    end else begin
      if (i_dem_we) begin
        s_d.mem[i_dem_addr] = i_dem_data;
      end
      // A host write to the same byte loses to the demodulator.
      if (i_host_we && !(i_dem_we && i_dem_addr == i_host_addr)) begin
        s_d.mem[i_host_addr] = i_host_data;
      end
      if (i_host_re) begin
        s_d.rdata = s_q.mem[i_host_addr];
      end
    end
  end

  // State register, frozen while the enable is low.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.rdata;

endmodule : srcs_buffer

// ===== srcs_timer.sv
// Absolute receive timeout timer counted in symbol periods.
// Assumes start is a one-cycle pulse and stop holds it idle.
module srcs_timer #(
  parameter int unsigned SYM_W = 16,
  parameter int unsigned CNT_W = 10
) (
  // Clock, reset and enable.
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Control.
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic [SYM_W-1:0] i_sym_cycles,
  input wire logic [CNT_W-1:0] i_symbols,
  // One-cycle expiry pulse.
  output logic o_expire
);

  // All state of the timer.
  typedef struct packed {
    logic run;
    logic [SYM_W-1:0] cyc;
    logic [CNT_W-1:0] syms;
    logic expire;
  } srcs_tmr_t;

  srcs_tmr_t s_q;
  srcs_tmr_t s_d;

  // Counts clocks within a symbol, then symbols up to the limit.
  always_comb begin
    s_d = s_q;
    s_d.expire = 1'b0;
    if (i_stop) begin
      s_d.run = 1'b0;
    end else if (i_start) begin
      // A zero symbol count disables the timeout.
      s_d.run = (i_symbols != '0);
      s_d.cyc = '0;
      s_d.syms = '0;
    end else if (s_q.run) begin
      if (s_q.cyc + 1'b1 >= i_sym_cycles) begin
        s_d.cyc = '0;
        s_d.syms = s_q.syms + 1'b1;
        if (s_q.syms + 1'b1 >= i_symbols) begin
          s_d.run = 1'b0;
          s_d.expire = 1'b1;
        end
      end else begin
        s_d.cyc = s_q.cyc + 1'b1;
      end
    end
  end

  // State register, frozen while the enable is low.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  assign o_expire = s_q.expire;

endmodule : srcs_timer

// ===== srcs_sequencer.sv
// Receive and channel-activity mode sequencer with event pin routing.
// Assumes demodulator events are one-cycle pulses on the system clock.
//
// Summary of operation
// - Single receive: preamble fixes gain, header flags.
// - Single done: flag, then standby, RF off.
// - Continuous: flag every packet, stay receiving.
// - Status holds only the latest packet.
// - Protection stops writes at transmit pointer.
// - Keep received count and last write pointer.
// - Timeout starts on receive entry, absolute.
// - Timeout equals symbols times symbol period.
// - Timeout expiry returns to standby.
// - Scan without auto receive ends in standby.
// - Scan with auto receive enters single receive on activity.
// - Route code 00 pin assignment.
// - Route code 01 pin assignment.
// - Route code 10 assignment; 11 assigns nothing.
// - Buffer data access advances access pointer.
// - Receive status cleared on receive entry.
// - Buffer lost and unreachable in sleep.
module srcs_sequencer #(
  parameter int unsigned SYM_W = 16,
  parameter int unsigned TMO_W = 10
) (
  // Clock, reset and enable.
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Host mode request and configuration.
  input wire logic i_mode_req_vld,
  input wire logic [2:0] i_mode_req,
  input wire logic i_activity_starts_receive,
  input wire logic i_transmit_area_protect,
  input wire logic [srcs_pkg::ADDR_W-1:0] i_receive_base_address,
  input wire logic [srcs_pkg::ADDR_W-1:0] i_transmit_base_address,
  input wire logic [TMO_W-1:0] i_timeout_symbol_count,
  input wire logic [SYM_W-1:0] i_symbol_cycles,
  input wire logic [11:0] i_pin_route,
  input wire logic [srcs_pkg::NUM_FLAGS-1:0] i_flag_clear,
  // Host buffer access.
  input wire logic i_ptr_load,
  input wire logic [srcs_pkg::ADDR_W-1:0] i_ptr_value,
  input wire logic i_buf_wr,
  input wire logic i_buf_rd,
  input wire logic [srcs_pkg::DATA_W-1:0] i_buf_wdata,
  // Demodulator and radio events.
  input wire logic i_preamble_ok,
  input wire logic i_header_ok,
  input wire logic i_rx_byte_vld,
  input wire logic [srcs_pkg::DATA_W-1:0] i_rx_byte,
  input wire logic i_packet_end,
  input wire logic i_payload_bad,
  input wire logic i_scan_end,
  input wire logic i_scan_activity,
  input wire logic i_tx_end,
  input wire logic i_hop_event,
  input wire logic i_synth_locked,
  // Status outputs.
  output logic [2:0] o_mode,
  output logic o_rf_on,
  output logic o_gain_fixed,
  output logic [srcs_pkg::NUM_FLAGS-1:0] o_flags,
  output logic [srcs_pkg::ADDR_W-1:0] o_buffer_access_pointer,
  output logic [srcs_pkg::ADDR_W-1:0] o_last_write_pointer,
  output logic [srcs_pkg::ADDR_W:0] o_received_byte_count,
  output logic [srcs_pkg::DATA_W-1:0] o_buf_rdata,
  // General pins.
  output logic [5:0] o_general_pin
);

  // All state of the sequencer.
  typedef struct packed {
    srcs_pkg::srcs_mode_t mode;
    srcs_pkg::srcs_rx_t rx;
    logic gain_fixed;
    logic [srcs_pkg::NUM_FLAGS-1:0] flags;
    logic [srcs_pkg::ADDR_W-1:0] aptr;
    logic [srcs_pkg::ADDR_W-1:0] wptr;
    logic [srcs_pkg::ADDR_W:0] count;
    logic mode_ready;
    logic [3:0] div;
    logic clk_out;
    logic [5:0] pins;
  } srcs_state_t;

  srcs_state_t s_q;
  srcs_state_t s_d;

  // Decode of a request code into a mode; unknown codes mean standby.
  function automatic srcs_pkg::srcs_mode_t req_to_mode(
    input logic [2:0] code
  );
    srcs_pkg::srcs_mode_t m;
    m = srcs_pkg::M_STANDBY;
    if (code == srcs_pkg::REQ_SLEEP) m = srcs_pkg::M_SLEEP;
    if (code == srcs_pkg::REQ_TX) m = srcs_pkg::M_TX;
    if (code == srcs_pkg::REQ_RX_CONT) m = srcs_pkg::M_RX_CONT;
    if (code == srcs_pkg::REQ_RX_SINGLE) m = srcs_pkg::M_RX_SINGLE;
    if (code == srcs_pkg::REQ_SCAN) m = srcs_pkg::M_SCAN;
    return m;
  endfunction : req_to_mode

  // True for both receive modes.
  function automatic logic is_rx(input srcs_pkg::srcs_mode_t m);
    return (m == srcs_pkg::M_RX_CONT) || (m == srcs_pkg::M_RX_SINGLE);
  endfunction : is_rx

  // Selects one pin's event for a route code and pin index.
  function automatic logic route_pin(
    input logic [1:0] code,
    input int unsigned pin,
    input logic [srcs_pkg::NUM_FLAGS-1:0] f,
    input logic rdy,
    input logic lock,
    input logic ck
  );
    logic [5:0] a;
    logic [5:0] b;
    logic [5:0] c;
    a = {rdy, f[srcs_pkg::F_ACTIVITY], f[srcs_pkg::F_SCAN_DONE],
         f[srcs_pkg::F_HOP], f[srcs_pkg::F_TIMEOUT],
         f[srcs_pkg::F_RX_DONE]};
    b = {ck, lock, f[srcs_pkg::F_HEADER], f[srcs_pkg::F_HOP],
         f[srcs_pkg::F_HOP], f[srcs_pkg::F_TX_DONE]};
    c = {ck, lock, f[srcs_pkg::F_CRC_ERR], f[srcs_pkg::F_HOP],
         f[srcs_pkg::F_ACTIVITY], f[srcs_pkg::F_SCAN_DONE]};
    unique case (code)
      srcs_pkg::ROUTE_A: return a[pin];
      srcs_pkg::ROUTE_B: return b[pin];
      srcs_pkg::ROUTE_C: return c[pin];
      srcs_pkg::ROUTE_NONE: return 1'b0;
    endcase
  endfunction : route_pin

  // Internal nets between the sequencer, timer and buffer.
  logic rx_enter; // Pulses when a receive mode is newly entered.
  logic timeout; // Timer expiry pulse.
  logic dem_we; // Demodulator byte accepted into the buffer.
  logic buf_ok; // Buffer reachable: not asleep.
  logic wipe; // Buffer wipe on entry to sleep.
  srcs_pkg::srcs_mode_t req_mode;

  assign req_mode = req_to_mode(i_mode_req);
  assign rx_enter = (s_d.mode != s_q.mode) && is_rx(s_d.mode) ||
                    (i_mode_req_vld && is_rx(req_mode));
  assign buf_ok = (s_q.mode != srcs_pkg::M_SLEEP);
  assign wipe = i_mode_req_vld && (req_mode == srcs_pkg::M_SLEEP) &&
                buf_ok;
  // Bytes are stored only during payload and short of the transmit area.
  assign dem_we = is_rx(s_q.mode) && (s_q.rx == srcs_pkg::RX_PAYLOAD) &&
                  i_rx_byte_vld &&
                  !(i_transmit_area_protect &&
                    s_q.wptr == i_transmit_base_address);

  // Next-state logic: mode sequencing, flags, pointers and pins.
  always_comb begin
    // Hardware sets of flags, collected then merged after host clears.
    logic [srcs_pkg::NUM_FLAGS-1:0] set;
    set = '0;
    s_d = s_q;
    s_d.mode_ready = 1'b1;

    // Sequencing within the current mode.
    unique case (s_q.mode)
      srcs_pkg::M_RX_SINGLE, srcs_pkg::M_RX_CONT: begin
        if (s_q.rx == srcs_pkg::RX_PREAMBLE && i_preamble_ok) begin
          s_d.rx = srcs_pkg::RX_HEADER;
          s_d.gain_fixed = 1'b1;
        end else if (s_q.rx == srcs_pkg::RX_HEADER && i_header_ok) begin
          set[srcs_pkg::F_HEADER] = 1'b1;
          s_d.rx = srcs_pkg::RX_PAYLOAD;
        end else if (s_q.rx == srcs_pkg::RX_PAYLOAD && i_packet_end) begin
          set[srcs_pkg::F_RX_DONE] = 1'b1;
          set[srcs_pkg::F_CRC_ERR] = i_payload_bad;
          s_d.rx = srcs_pkg::RX_PREAMBLE;
          s_d.gain_fixed = 1'b0;
          if (s_q.mode == srcs_pkg::M_RX_SINGLE) begin
            s_d.mode = srcs_pkg::M_STANDBY;
          end
        end
        // Continuous mode keeps listening after each packet.
        if (timeout) begin
          set[srcs_pkg::F_TIMEOUT] = 1'b1;
          s_d.mode = srcs_pkg::M_STANDBY;
          s_d.rx = srcs_pkg::RX_PREAMBLE;
          s_d.gain_fixed = 1'b0;
        end
      end
      srcs_pkg::M_SCAN: begin
        if (i_scan_end) begin
          set[srcs_pkg::F_SCAN_DONE] = 1'b1;
          set[srcs_pkg::F_ACTIVITY] = i_scan_activity;
          if (i_activity_starts_receive && i_scan_activity) begin
            s_d.mode = srcs_pkg::M_RX_SINGLE;
            s_d.rx = srcs_pkg::RX_PREAMBLE;
          end else begin
            s_d.mode = srcs_pkg::M_STANDBY;
          end
        end
      end
      srcs_pkg::M_TX: begin
        if (i_tx_end) begin
          set[srcs_pkg::F_TX_DONE] = 1'b1;
          s_d.mode = srcs_pkg::M_STANDBY;
        end
      end
      srcs_pkg::M_SLEEP, srcs_pkg::M_STANDBY: begin
      end
    endcase

    // Frequency hop events are recorded in any mode.
    set[srcs_pkg::F_HOP] = i_hop_event;

    // A host mode request overrides automatic sequencing.
    if (i_mode_req_vld) begin
      s_d.mode = req_mode;
      s_d.rx = srcs_pkg::RX_PREAMBLE;
      s_d.gain_fixed = 1'b0;
    end

    // Mode ready drops for the cycle after any mode change.
    if (s_d.mode != s_q.mode) begin
      s_d.mode_ready = 1'b0;
    end

    // Fresh receive entry clears status; write pointer restarts.
    if (rx_enter) begin
      s_d.count = '0;
      s_d.wptr = i_receive_base_address;
    end else if (dem_we) begin
      s_d.count = s_q.count + 1'b1;
      s_d.wptr = s_q.wptr + 1'b1;
    end

    // Latest packet only: count restarts at each header.
    if (set[srcs_pkg::F_HEADER]) begin
      s_d.count = '0;
    end

    // Flags hold until cleared; a same-cycle set beats the clear.
    s_d.flags = (s_q.flags & ~i_flag_clear) | set;

    // Host access pointer: load, else advance on each data access.
    if (i_ptr_load) begin
      s_d.aptr = i_ptr_value;
    end else if (buf_ok && (i_buf_rd || i_buf_wr)) begin
      s_d.aptr = s_q.aptr + 1'b1;
    end

    // Free-running clock output divider.
    if (s_q.div == srcs_pkg::CLOCK_OUTPUT_HALF_M1) begin
      s_d.div = '0;
      s_d.clk_out = ~s_q.clk_out;
    end else begin
      s_d.div = s_q.div + 1'b1;
    end

    // Pin routing from registered flags, each pin its own code.
    for (int unsigned p = 0; p < 6; p++) begin
      s_d.pins[p] = route_pin(i_pin_route[2*p +: 2], p, s_q.flags,
                              s_q.mode_ready, i_synth_locked,
                              s_q.clk_out);
    end
  end

  // State register, frozen while the enable is low.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '{mode: srcs_pkg::M_SLEEP, rx: srcs_pkg::RX_PREAMBLE,
               gain_fixed: 1'b0, flags: srcs_pkg::FLAGS_RST,
               aptr: srcs_pkg::PTR_RST, wptr: srcs_pkg::PTR_RST,
               count: '0, mode_ready: 1'b0, div: '0,
               clk_out: 1'b0, pins: '0};
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  // Timeout timer, restarted on every receive entry.
  srcs_timer #(
    .SYM_W(SYM_W),
    .CNT_W(TMO_W)
  ) u_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_start(rx_enter),
    .i_stop(!is_rx(s_d.mode) && !rx_enter),
    .i_sym_cycles(i_symbol_cycles),
    .i_symbols(i_timeout_symbol_count),
    .o_expire(timeout)
  );

  // Shared data buffer; host access only while awake.
  srcs_buffer #(
    .DEPTH(srcs_pkg::BUF_DEPTH)
  ) u_buffer (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_clear(wipe),
    .i_dem_we(dem_we),
    .i_dem_addr(s_q.wptr),
    .i_dem_data(i_rx_byte),
    .i_host_we(i_buf_wr && buf_ok && !i_ptr_load),
    .i_host_re(i_buf_rd && buf_ok && !i_ptr_load),
    .i_host_addr(s_q.aptr),
    .i_host_data(i_buf_wdata),
    .o_rdata(o_buf_rdata)
  );

  // Outputs straight from state flip-flops; RF-on is decoded from the mode.
  assign o_mode = s_q.mode;
  assign o_rf_on = (s_q.mode != srcs_pkg::M_SLEEP) &&
                   (s_q.mode != srcs_pkg::M_STANDBY);
  assign o_gain_fixed = s_q.gain_fixed;
  assign o_flags = s_q.flags;
  assign o_buffer_access_pointer = s_q.aptr;
  assign o_last_write_pointer = s_q.wptr;
  assign o_received_byte_count = s_q.count;
  assign o_general_pin = s_q.pins;

endmodule : srcs_sequencer

// ===== srcs_chk.sv
// Concurrent checks on the sequencer's mode moves, flags and pins.
// Assumes one clock; attached by bind to the sequencer's ports.
module srcs_chk (
  // Clock and reset.
  input logic i_sys_clk,
  input logic i_rst_n,
  // Watched inputs.
  input logic i_mode_req_vld,
  input logic i_activity_starts_receive,
  input logic i_transmit_area_protect,
  input logic [7:0] i_transmit_base_address,
  input logic [11:0] i_pin_route,
  input logic [7:0] i_flag_clear,
  input logic i_ptr_load,
  input logic i_buf_rd,
  input logic i_preamble_ok,
  input logic i_header_ok,
  input logic i_rx_byte_vld,
  input logic i_packet_end,
  input logic i_scan_end,
  input logic i_scan_activity,
  // Watched outputs.
  input logic [2:0] o_mode,
  input logic o_gain_fixed,
  input logic [7:0] o_flags,
  input logic [7:0] o_buffer_access_pointer,
  input logic [7:0] o_last_write_pointer,
  input logic [5:0] o_general_pin
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // Receiving, with no competing host request.
  wire rx = (o_mode == 3'h3 || o_mode == 3'h4) && !i_mode_req_vld;
  // A scan ending, with no competing request.
  wire scan = o_mode == 3'h5 && !i_mode_req_vld && i_scan_end;

  a_gain_on_preamble: assert property (rx && i_preamble_ok |=> o_gain_fixed)
    else $error("gain not fixed");
  a_header_flag_set: assert property (rx && i_header_ok |=> o_flags[2])
    else $error("no header flag");
  a_single_done: assert property (o_mode == 3'h4 && !i_mode_req_vld
    && i_packet_end |=> o_mode == 3'h1 && o_flags[0])
    else $error("bad single end");
  a_cont_stays: assert property (o_mode == 3'h3 && !i_mode_req_vld
    && i_packet_end |=> o_mode == 3'h3 && o_flags[0])
    else $error("bad continuous end");
  a_protect_hold: assert property (rx && i_rx_byte_vld
    && i_transmit_area_protect
    && o_last_write_pointer == i_transmit_base_address
    |=> $stable(o_last_write_pointer))
    else $error("protect failed");
  a_write_advance: assert property (rx && i_rx_byte_vld
    && !i_transmit_area_protect
    |=> o_last_write_pointer == $past(o_last_write_pointer) + 8'h1)
    else $error("write ptr stuck");
  a_read_advance: assert property (o_mode != 3'h0 && i_buf_rd
    && !i_ptr_load
    |=> o_buffer_access_pointer == $past(o_buffer_access_pointer) + 8'h1)
    else $error("access ptr stuck");
  a_sleep_no_read: assert property (o_mode == 3'h0 && i_buf_rd
    && !i_ptr_load && !i_mode_req_vld |=> $stable(o_buffer_access_pointer))
    else $error("sleep access");
  a_timeout_leave: assert property ($rose(o_flags[1])
    && !$past(i_mode_req_vld) |-> o_mode == 3'h1)
    else $error("timeout mode");
  a_scan_plain: assert property (scan && !i_activity_starts_receive
    |=> o_mode == 3'h1 && o_flags[4])
    else $error("plain scan end");
  a_scan_auto: assert property (scan && i_activity_starts_receive
    && i_scan_activity |=> o_mode == 3'h4 && o_flags[5] && o_flags[4])
    else $error("auto scan end");
  a_flags_sticky: assert property (1'b1
    |=> (~o_flags & $past(o_flags) & ~$past(i_flag_clear)) == 8'h00)
    else $error("flag dropped");
  a_route_a_pin0: assert property ($past(i_pin_route[1:0]) == 2'h0
    |-> o_general_pin[0] == $past(o_flags[0]))
    else $error("route a pin 0");
  a_route_b_pin3: assert property ($past(i_pin_route[7:6]) == 2'h1
    |-> o_general_pin[3] == $past(o_flags[2]))
    else $error("route b pin 3");
  a_route_c_pin3: assert property ($past(i_pin_route[7:6]) == 2'h2
    |-> o_general_pin[3] == $past(o_flags[3]))
    else $error("route c pin 3");
  a_route_none: assert property ($past(i_pin_route[9:8]) == 2'h3
    |-> !o_general_pin[4])
    else $error("unrouted pin 4");
endmodule : srcs_chk

// ===== srcs_host.sv
// Host model: mode requests, flag clearing and packet extraction.
// Assumes callers enter its tasks after a rising clock edge.
module srcs_host (
  // Clock.
  input wire logic i_sys_clk,
  // Status read back from the sequencer.
  input wire logic [7:0] i_flags,
  input wire logic [7:0] i_last_write_pointer,
  input wire logic [8:0] i_received_byte_count,
  // Requests toward the sequencer.
  output logic o_mode_req_vld,
  output logic [2:0] o_mode_req,
  output logic [7:0] o_flag_clear,
  output logic o_ptr_load,
  output logic [7:0] o_ptr_value,
  output logic o_buf_rd
);
  // Everything idle at time zero.
  initial begin
    {o_mode_req_vld, o_mode_req, o_flag_clear} = '0;
    {o_ptr_load, o_ptr_value, o_buf_rd} = '0;
  end
  // One mode request.
  task automatic req(input logic [2:0] code);
    @(posedge i_sys_clk);
    o_mode_req_vld <= 1'b1;
    o_mode_req <= code;
    @(posedge i_sys_clk);
    o_mode_req_vld <= 1'b0;
  endtask : req
  // Stale flags are wiped by one cycle of all-ones flag clear.
  task automatic clear_all();
    @(posedge i_sys_clk);
    o_flag_clear <= 8'hff;
    @(posedge i_sys_clk);
    o_flag_clear <= 8'h00;
  endtask : clear_all
  // Load the access pointer.
  task automatic load(input logic [7:0] a);
    @(posedge i_sys_clk);
    o_ptr_load <= 1'b1;
    o_ptr_value <= a;
    @(posedge i_sys_clk);
    o_ptr_load <= 1'b0;
  endtask : load
  // Back-to-back data port reads.
  task automatic read(input int n);
    repeat (n) @(posedge i_sys_clk) o_buf_rd <= 1'b1;
    @(posedge i_sys_clk);
    o_buf_rd <= 1'b0;
  endtask : read
  // Extract the last good packet.
  task automatic extract();
    int n;
    @(negedge i_sys_clk);
    if (i_flags[3] || i_flags[1]) return;
    n = int'(i_received_byte_count);
    load(i_last_write_pointer - i_received_byte_count[7:0]);
    read(n);
  endtask : extract
endmodule : srcs_host

// ===== srcs_tb.sv
// Self-checking bench for the receive and scan sequencer.
// Assumes the design files and the host model are compiled.
bind srcs_sequencer srcs_chk chk (.*);
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // Stimulus: event bits are preamble, header, byte, end, scan, tx, hop.
  logic clk, rst_n, auto, prot, lock, qual, rd_d, awake;
  logic [6:0] ev;
  logic [7:0] rxb, txb, bval, fclr, pval, flags, aptr, wptr, rdata;
  logic [9:0] tmo;
  logic [11:0] route;
  logic vld, ld, rd, rf, gain, ce, wr;
  logic [7:0] wd;
  logic [15:0] sym;
  logic [2:0] mreq, mode;
  logic [8:0] cnt;
  logic [5:0] pins;
  logic [31:0] seed;
  logic [7:0] exp_q[$];
  logic [4:0] tbl[4];
  int fail_count, checked, k;
  srcs_sequencer uut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
    .i_mode_req_vld(vld), .i_mode_req(mreq),
    .i_activity_starts_receive(auto), .i_transmit_area_protect(prot),
    .i_receive_base_address(rxb), .i_transmit_base_address(txb),
    .i_timeout_symbol_count(tmo), .i_symbol_cycles(sym),
    .i_pin_route(route), .i_flag_clear(fclr), .i_ptr_load(ld),
    .i_ptr_value(pval), .i_buf_wr(wr), .i_buf_rd(rd),
    .i_buf_wdata(wd), .i_preamble_ok(ev[0]), .i_header_ok(ev[1]),
    .i_rx_byte_vld(ev[2]), .i_rx_byte(bval), .i_packet_end(ev[3]),
    .i_payload_bad(qual), .i_scan_end(ev[4]), .i_scan_activity(qual),
    .i_tx_end(ev[5]), .i_hop_event(ev[6]), .i_synth_locked(lock),
    .o_mode(mode), .o_rf_on(rf), .o_gain_fixed(gain), .o_flags(flags),
    .o_buffer_access_pointer(aptr), .o_last_write_pointer(wptr),
    .o_received_byte_count(cnt), .o_buf_rdata(rdata),
    .o_general_pin(pins));
  srcs_host host (.i_sys_clk(clk), .i_flags(flags),
    .i_last_write_pointer(wptr), .i_received_byte_count(cnt),
    .o_mode_req_vld(vld), .o_mode_req(mreq), .o_flag_clear(fclr),
    .o_ptr_load(ld), .o_ptr_value(pval), .o_buf_rd(rd));
  // Free-running clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Compare and count.
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Verdict.
  task automatic stop_test();
    if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // One event pulse with its qualifier.
  task automatic pulse(logic [6:0] m, logic q);
    @(posedge clk);
    ev <= m;
    qual <= q;
    @(posedge clk);
    ev <= 7'h00;
  endtask : pulse
  // Random payload bytes; kept ones are noted as expected read data.
  task automatic send(int n, logic keep);
    repeat (n) begin
      seed = xs(seed);
      @(posedge clk);
      ev <= 7'h04;
      bval <= seed[7:0];
      if (keep) exp_q.push_back(seed[7:0]);
    end
    @(posedge clk);
    ev <= 7'h00;
  endtask : send
  // Read data lands one cycle after an accepted read.
  always @(posedge clk) rd_d <= rd && awake;
  always @(negedge clk) begin
    if (rd_d && exp_q.size() == 0) chk("unexpected read", 0, 1);
    else if (rd_d) chk("read data", exp_q.pop_front(), rdata);
  end
  // Watchdog.
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    stop_test();
  end
  initial begin
    {auto, prot, lock, qual, ev, rxb, txb, bval, tmo, route, awake} = '0;
    {wr, wd, ce, sym} = {9'h000, 1'b1, 16'h0002};
    tbl = '{5'h1c, 5'h16, 5'h17, 5'h00};
    seed = 32'h785a034b;
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("reset mode", 3'h0, mode);
    host.req(3'h1);
    awake = 1'b1;
    rxb <= 8'h10;
    txb <= 8'h80;
    host.load(8'h10);
    host.req(3'h6);
    pulse(7'h01, 1'b0);
    @(negedge clk);
    chk("gain", 1, gain);
    pulse(7'h02, 1'b0);
    send(4, 1'b1);
    pulse(7'h08, 1'b0);
    @(negedge clk);
    chk("single flags", 8'h05, flags);
    chk("single mode", 3'h1, mode);
    chk("rf", 0, rf);
    chk("count", 4, cnt);
    chk("write ptr", 8'h14, wptr);
    host.extract();
    @(negedge clk);
    chk("access ptr", 8'h14, aptr);
    host.clear_all();
    host.req(3'h5);
    pulse(7'h01, 1'b0);
    pulse(7'h02, 1'b0);
    send(2, 1'b0);
    pulse(7'h08, 1'b1);
    @(negedge clk);
    chk("bad flags", 8'h0d, flags);
    chk("cont mode", 3'h3, mode);
    host.extract();
    host.clear_all();
    pulse(7'h01, 1'b0);
    pulse(7'h02, 1'b0);
    send(3, 1'b1);
    pulse(7'h08, 1'b0);
    @(negedge clk);
    chk("cont count", 3, cnt);
    chk("cont mode", 3'h3, mode);
    host.extract();
    host.req(3'h1);
    tmo <= 10'h003;
    host.clear_all();
    host.req(3'h6);
    for (k = 0; k < 40 && flags[1] !== 1'b1; k++) @(negedge clk);
    chk("timeout span", 1, k > 4 && k < 11);
    chk("timeout mode", 3'h1, mode);
    tmo <= 10'h000;
    prot <= 1'b1;
    rxb <= 8'h7e;
    host.clear_all();
    host.req(3'h6);
    pulse(7'h01, 1'b0);
    pulse(7'h02, 1'b0);
    send(4, 1'b0);
    @(negedge clk);
    chk("protect ptr", 8'h80, wptr);
    host.req(3'h1);
    prot <= 1'b0;
    host.clear_all();
    host.req(3'h7);
    pulse(7'h10, 1'b1);
    @(negedge clk);
    chk("scan mode", 3'h1, mode);
    chk("scan rf", 0, rf);
    auto <= 1'b1;
    host.req(3'h7);
    pulse(7'h10, 1'b1);
    @(negedge clk);
    chk("auto mode", 3'h4, mode);
    host.req(3'h1);
    lock <= 1'b1;
    pulse(7'h40, 1'b0);
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      route <= {6{c[1:0]}};
      repeat (3) @(negedge clk);
      chk("pins", tbl[c], pins[4:0]);
      if (c == 0) chk("ready pin", 1, pins[5]);
      if (c == 3) chk("idle pin", 0, pins[5]);
    end
    @(posedge clk) ce <= 1'b0;
    host.req(3'h0);
    @(negedge clk);
    chk("frozen mode", 3'h1, mode);
    @(posedge clk) ce <= 1'b1;
    host.req(3'h0);
    awake = 1'b0;
    k = int'(aptr);
    host.read(1);
    @(negedge clk);
    chk("sleep ptr", k, aptr);
    host.req(3'h1);
    awake = 1'b1;
    host.load(8'h10);
    @(posedge clk) {wr, wd} <= {1'b1, seed[15:8]};
    @(posedge clk) wr <= 1'b0;
    host.load(8'h10);
    exp_q.push_back(seed[15:8]);
    exp_q.push_back(8'h00);
    host.read(2);
    repeat (2) @(negedge clk);
    chk("queue left", 0, exp_q.size());
    stop_test();
  end
endmodule : testbench
